/* i2c_slave_register_pointer.sv */
// Functional notes
// - Respond only to address 0x36
// - First write byte loads pointer
// - Pointer increments after each byte, except reads of 0x0c/0x0e/0x1b
// - Invalid word address NACKed, transfer continues
// - Invalid read returns zeros, increments
// - Reads wrap across full address range
// - Angle/raw/magnitude high byte holds pointer
// - Invalid writes NACKed, dropped; valid ACKed
// - Page writes wrap on overflow
// - START: SDA falls while SCL high
// - STOP: SDA rises while SCL high
// - SDA changes only while SCL low
// - Bytes MSB first plus ack bit
// - ACK holds SDA low whole high phase
// - Master NACK ends read; release SDA
// - Direction bit: 0 write, 1 read
// - Read starts at current pointer
// - Repeated START begins new transfer
// - Master sets byte count, no limit
// - Filter out pulses under 50 ns
// - ACK address after match
// - Never drive SCL low
module i2c_slave_register_pointer
  import i2c_ptr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  i2c_bus_if.slave bus,
  output logic [7:0] regAddr,
  output logic [7:0] wrData,
  output logic wrStrobe,
  input wire logic [7:0] rdData,
  output logic busy
);
  typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WORD, ST_WORD_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK, ST_SKIP} state_t;

  logic [1:0] sclSync_r;
  logic [1:0] sdaSync_r;
  logic [3:0] sclCnt_r;
  logic [3:0] sdaCnt_r;
  logic sclF_r;
  logic sdaF_r;
  state_t state_r;
  logic [3:0] bitCnt_r;
  logic [7:0] shift_r;
  logic [7:0] ptr_r;
  logic [7:0] txByte_r;
  logic ackDrive_r;
  logic sdaOut_r;
  logic sdaOe_r;
  logic [7:0] wrData_r;
  logic wrStrobe_r;
  logic busy_r;

  // Two flops, then a counting spike filter on each line
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclSync_r <= 2'h3;
      sdaSync_r <= 2'h3;
    end else begin
      sclSync_r <= {sclSync_r[0], bus.scl};
      sdaSync_r <= {sdaSync_r[0], bus.sda};
    end
  end

  wire logic sclS = sclSync_r[1];
  wire logic sdaS = sdaSync_r[1];
  wire logic sclDiff = sclS != sclF_r;
  wire logic sdaDiff = sdaS != sdaF_r;
  wire logic sclDone = sclDiff && (sclCnt_r == 4'(FILT_CYC));
  wire logic sdaDone = sdaDiff && (sdaCnt_r == 4'(FILT_CYC));

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclCnt_r <= 4'h0;
      sdaCnt_r <= 4'h0;
      sclF_r <= 1'b1;
      sdaF_r <= 1'b1;
    end else begin
      sclCnt_r <= (sclDiff && !sclDone) ? sclCnt_r + 4'h1 : 4'h0;
      sdaCnt_r <= (sdaDiff && !sdaDone) ? sdaCnt_r + 4'h1 : 4'h0;
      if (sclDone) sclF_r <= sclS;
      if (sdaDone) sdaF_r <= sdaS;
    end
  end

  // Protocol events from filtered lines
  wire logic sclRise = sclDone && sclS;
  wire logic sclFall = sclDone && !sclS;
  wire logic startCond = sdaDone && !sdaS && sclF_r;
  wire logic stopCond = sdaDone && sdaS && sclF_r;

  wire logic byteDone = sclRise && (bitCnt_r == 4'h7);
  wire logic [7:0] rxByte = {shift_r[6:0], sdaF_r};
  wire logic addrHit = rxByte[7:1] == SLAVE_ADDR;
  wire logic isRead = rxByte[0];
  wire logic ptrValid = regValid(ptr_r);
  wire logic [7:0] ptrInc = ptr_r + 8'h1;
  wire logic [7:0] txLoad = ptrValid ? rdData : 8'h00;
  wire logic [7:0] rdStep = regHoldsPtr(ptr_r) ? ptr_r : ptrInc;
  // First SCL fall of a read byte loads, later ones shift
  wire logic txFirst = (state_r == ST_RDATA) && (bitCnt_r == 4'h0);
  wire logic txShift = (state_r == ST_RDATA) && (bitCnt_r != 4'h0);

  // Protocol engine, driven by filtered SCL edges
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      txByte_r <= 8'h00;
      ackDrive_r <= 1'b0;
      wrData_r <= 8'h00;
      wrStrobe_r <= 1'b0;
    end else begin
      wrStrobe_r <= 1'b0;
      if (startCond) begin
        state_r <= ST_ADDR;
        bitCnt_r <= 4'h0;
        ackDrive_r <= 1'b0;
      end else if (stopCond) begin
        state_r <= ST_IDLE;
        ackDrive_r <= 1'b0;
      end else if (sclRise) begin
        bitCnt_r <= (bitCnt_r == 4'h8) ? 4'h0 : bitCnt_r + 4'h1;
        shift_r <= rxByte;
        unique case (state_r)
          ST_IDLE, ST_SKIP: ;
          // Address byte: match and direction
          ST_ADDR: if (byteDone) begin
            state_r <= addrHit ? ST_ADDR_ACK : ST_SKIP;
            ackDrive_r <= addrHit;
            if (addrHit && isRead) txByte_r <= txLoad;
          end
          // Word address loads the pointer
          ST_WORD: if (byteDone) begin
            ptr_r <= rxByte;
            ackDrive_r <= regValid(rxByte);
            state_r <= ST_WORD_ACK;
          end
          // Data byte in, stored while pointer is still unchanged
          ST_WDATA: if (byteDone) begin
            ackDrive_r <= ptrValid;
            wrStrobe_r <= ptrValid;
            wrData_r <= rxByte;
            state_r <= ST_WDATA_ACK;
          end
          ST_RDATA: if (byteDone) state_r <= ST_RDATA_ACK;
          // Ack bit rise: pick the data phase
          ST_ADDR_ACK: state_r <= shift_r[0] ? ST_RDATA : ST_WORD;
          ST_WORD_ACK: state_r <= ST_WDATA;
          // Step the pointer after each byte
          ST_WDATA_ACK: begin
            ptr_r <= ptrInc;
            state_r <= ST_WDATA;
          end
          // Master ack keeps reading, nack ends
          ST_RDATA_ACK: begin
            ptr_r <= rdStep;
            state_r <= sdaF_r ? ST_SKIP : ST_RDATA;
          end
        endcase
      end else if (sclFall) begin
        // Ack stays until the ack bit's SCL fall
        if (state_r == ST_ADDR_ACK || state_r == ST_WORD_ACK ||
            state_r == ST_WDATA_ACK) begin
          if (!ackDrive_r) ackDrive_r <= 1'b0;
        end else begin
          ackDrive_r <= 1'b0;
        end
        if (txShift) txByte_r <= {txByte_r[6:0], 1'b0};
        if (txFirst) txByte_r <= txLoad;
      end
    end
  end

  // Drive the current data bit or an ack low
  wire logic txBit = (state_r == ST_RDATA) && !txByte_r[7];
  wire logic drvLow = ackDrive_r || txBit;

  // SDA only moves while SCL is low, or is released on START/STOP
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sdaOut_r <= 1'b1;
      sdaOe_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      busy_r <= state_r != ST_IDLE;
      if (!sclF_r || startCond || stopCond) begin
        sdaOe_r <= drvLow && !startCond && !stopCond;
        sdaOut_r <= 1'b0;
      end
    end
  end

  // Outputs straight from flops
  assign bus.sdaSlvOut = sdaOut_r;
  assign bus.sdaSlvOe = sdaOe_r;
  assign regAddr = ptr_r;
  assign wrData = wrData_r;
  assign wrStrobe = wrStrobe_r;
  assign busy = busy_r;
endmodule

/* i2c_ptr_pkg.sv */
package i2c_ptr_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h36;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SYS_CLK_MHZ = 250;
  localparam int SPIKE_NS = 50;
  // Spike filter length: pulses of this many cycles or fewer are dropped
  localparam int FILT_CYC = (SPIKE_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int SCL_HALF_DIV = 63;
  localparam logic [7:0] REG_ZMCO = 8'h00;
  localparam logic [7:0] REG_CONF_HI = 8'h07;
  localparam logic [7:0] REG_CONF_LO = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0b;
  localparam logic [7:0] REG_RAW_HI = 8'h0c;
  localparam logic [7:0] REG_ANGLE_LO = 8'h0f;
  localparam logic [7:0] REG_AGC = 8'h1a;
  localparam logic [7:0] REG_MAG_HI = 8'h1b;
  localparam logic [7:0] REG_MAG_LO = 8'h1c;
  localparam logic [7:0] REG_ANGLE_HI = 8'h0e;
  localparam logic [7:0] REG_BURN = 8'hff;

  function automatic logic regValid(input logic [7:0] a);
    return (a <= REG_CONF_LO) || (a >= REG_STATUS && a <= REG_ANGLE_LO) ||
      (a >= REG_AGC && a <= REG_MAG_LO) || (a == REG_BURN);
  endfunction

  function automatic logic regHoldsPtr(input logic [7:0] a);
    return (a == REG_RAW_HI) || (a == REG_ANGLE_HI) || (a == REG_MAG_HI);
  endfunction
endpackage

/* i2c_bus_if.sv */
interface i2c_bus_if;
  logic sclOut;
  logic sclOe;
  logic sdaMstOut;
  logic sdaMstOe;
  logic sdaSlvOut;
  logic sdaSlvOe;
  wire scl;
  wire sda;
  // Open-drain resolution, pulled up when nobody drives low
  assign scl = (sclOe && !sclOut) ? 1'b0 : 1'b1;
  assign sda = ((sdaMstOe && !sdaMstOut) || (sdaSlvOe && !sdaSlvOut)) ?
    1'b0 : 1'b1;
  modport slave (input scl, input sda, output sdaSlvOut, output sdaSlvOe);
  modport master (input scl, input sda, output sclOut, output sclOe,
    output sdaMstOut, output sdaMstOe);
endinterface

/* i2c_bus_master.sv */
module i2c_bus_master
  import i2c_ptr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  i2c_bus_if.master bus,
  input wire logic cmdValid,
  input wire logic cmdRead,
  input wire logic [7:0] cmdAddr,
  input wire logic [7:0] cmdData,
  input wire logic cmdLast,
  output logic cmdReady,
  output logic [7:0] rspData,
  output logic rspAck,
  output logic rspValid
);
  typedef enum {M_IDLE, M_START, M_BIT, M_STOP} mstate_t;
  mstate_t state_r;
  logic [7:0] div_r;
  logic [1:0] phase_r;
  logic [3:0] bitCnt_r;
  logic [8:0] shift_r;
  logic [7:0] rx_r;
  logic sclOut_r;
  logic sdaOut_r;
  logic last_r;
  logic rd_r;
  logic ready_r;
  logic rspValid_r;
  logic rspAck_r;
  logic [7:0] rspData_r;
  logic [1:0] sdaSync_r;

  wire logic tick = div_r == 8'(SCL_HALF_DIV - 1);
  // Read bytes: release SDA, ack unless last
  wire logic [8:0] loadWord = cmdRead ? {8'hff, cmdLast} : {cmdData, 1'b1};

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sdaSync_r <= 2'h3;
      div_r <= 8'h00;
    end else begin
      sdaSync_r <= {sdaSync_r[0], bus.sda};
      div_r <= tick ? 8'h00 : div_r + 8'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= M_IDLE;
      phase_r <= 2'h0;
      bitCnt_r <= 4'h0;
      shift_r <= 9'h1ff;
      rx_r <= 8'h00;
      sclOut_r <= 1'b1;
      sdaOut_r <= 1'b1;
      last_r <= 1'b0;
      rd_r <= 1'b0;
      ready_r <= 1'b0;
      rspValid_r <= 1'b0;
      rspAck_r <= 1'b0;
      rspData_r <= 8'h00;
    end else begin
      rspValid_r <= 1'b0;
      ready_r <= 1'b0;
      if (tick) begin
        unique case (state_r)
          M_IDLE: if (cmdValid) begin
            ready_r <= 1'b1;
            shift_r <= {cmdAddr, 1'b1};
            rd_r <= 1'b0;
            last_r <= 1'b0;
            sdaOut_r <= 1'b0;
            state_r <= M_START;
          end
          M_START: begin
            sclOut_r <= 1'b0;
            phase_r <= 2'h0;
            bitCnt_r <= 4'h0;
            state_r <= M_BIT;
          end
          M_BIT: begin
            phase_r <= phase_r + 2'h1;
            unique case (phase_r)
              2'h0: sdaOut_r <= shift_r[8];
              2'h1: sclOut_r <= 1'b1;
              2'h2: begin
                if (bitCnt_r == 4'h8) rspAck_r <= !sdaSync_r[1];
                else rx_r <= {rx_r[6:0], sdaSync_r[1]};
              end
              2'h3: begin
                sclOut_r <= 1'b0;
                shift_r <= {shift_r[7:0], 1'b1};
                bitCnt_r <= bitCnt_r + 4'h1;
                if (bitCnt_r == 4'h8) begin
                  bitCnt_r <= 4'h0;
                  rspValid_r <= 1'b1;
                  rspData_r <= rx_r;
                  if (last_r || !cmdValid) begin
                    state_r <= M_STOP;
                    phase_r <= 2'h0;
                  end else begin
                    ready_r <= 1'b1;
                    rd_r <= cmdRead;
                    last_r <= cmdLast;
                    shift_r <= loadWord;
                  end
                end
              end
            endcase
          end
          M_STOP: begin
            phase_r <= phase_r + 2'h1;
            unique case (phase_r)
              2'h0: sdaOut_r <= 1'b0;
              2'h1: sclOut_r <= 1'b1;
              2'h2: sdaOut_r <= 1'b1;
              2'h3: state_r <= M_IDLE;
            endcase
          end
        endcase
      end
    end
  end

  assign bus.sclOut = sclOut_r;
  assign bus.sclOe = 1'b1;
  assign bus.sdaMstOut = sdaOut_r;
  assign bus.sdaMstOe = 1'b1;
  assign cmdReady = ready_r;
  assign rspData = rspData_r;
  assign rspAck = rspAck_r;
  assign rspValid = rspValid_r;
endmodule

/* i2c_slave_register_pointer_chk.sv */
module i2c_slave_register_pointer_chk
  import i2c_ptr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaSlvOut,
  input wire logic sdaSlvOe,
  input wire logic scl,
  input wire logic sda
);
  logic sclD, sdaD, first;
  logic [3:0] cnt;
  logic [7:0] sh;
  wire slvLow = sdaSlvOe && !sdaSlvOut;
  wire riseC = scl && !sclD;
  wire startC = scl && sclD && sdaD && !sda;
  wire stopC = scl && sclD && !sdaD && sda;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclD <= 1'b1;
      sdaD <= 1'b1;
    end else begin
      sclD <= scl;
      sdaD <= sda;
    end
  end
  // Bit count and address capture since START
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 4'h0;
      first <= 1'b0;
      sh <= 8'h00;
    end else if (startC) begin
      cnt <= 4'h0;
      first <= 1'b1;
    end else if (riseC) begin
      cnt <= cnt + 4'h1;
      sh <= {sh[6:0], sda};
      if (cnt == 4'h8) first <= 1'b0;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence stopSeq;
    stopC;
  endsequence
  sequence startSeq;
    startC;
  endsequence
  a_slave_sda_stable: assert property (scl && sclD |-> $stable(slvLow))
    else $error("slave sda moved while scl high");
  a_no_clk_stretch: assert property (!scl |-> sclOe && !sclOut)
    else $error("scl low without master");
  a_ack_held_low: assert property ($rose(scl) && slvLow |-> slvLow [*8])
    else $error("slave low not held in high phase");
  a_idle_after_stop: assert property (stopSeq |=> !slvLow [*8])
    else $error("slave drives after stop");
  a_start_quiet: assert property (startSeq |=> !slvLow [*8])
    else $error("slave drives after start");
  a_addr_quiet: assert property (riseC && first && cnt < 4'h8 |-> !slvLow)
    else $error("slave drives in address bits");
  a_addr_match: assert property (riseC && first && cnt == 4'h8 |->
    slvLow == (sh[7:1] == SLAVE_ADDR))
    else $error("address ack wrong");
  a_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
    else $error("scl low phase too short");
endmodule

/* i2c_slave_register_pointer_tb.sv */
module i2c_slave_register_pointer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import i2c_ptr_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] regAddr, wrData, rdData, cmdAddr, cmdData, rspData;
  logic wrStrobe, busy, cmdValid, cmdRead, cmdLast, cmdReady;
  logic rspAck, rspValid;
  logic [7:0] rspQ[$];
  logic ackQ[$];
  logic [15:0] wrQ[$];
  int n_mismatch = 0;
  int cmp_count = 0;
  always #2 sys_clk = ~sys_clk;
  i2c_bus_if bus();
  assign rdData = regAddr ^ 8'h5a;
  i2c_slave_register_pointer i2c_slave_register_pointer_inst (.sys_clk,
    .sys_rst, .bus(bus.slave), .regAddr, .wrData, .wrStrobe, .rdData, .busy);
  i2c_bus_master i2c_bus_master_inst (.sys_clk, .sys_rst, .bus(bus.master),
    .cmdValid, .cmdRead, .cmdAddr, .cmdData, .cmdLast, .cmdReady, .rspData,
    .rspAck, .rspValid);
  i2c_slave_register_pointer_chk i2c_slave_register_pointer_chk_inst (
    .sys_clk, .sys_rst, .sclOut(bus.sclOut), .sclOe(bus.sclOe),
    .sdaSlvOut(bus.sdaSlvOut), .sdaSlvOe(bus.sdaSlvOe), .scl(bus.scl),
    .sda(bus.sda));
  always @(posedge sys_clk) begin
    if (rspValid === 1'b1) begin
      rspQ.push_back(rspData);
      ackQ.push_back(rspAck);
    end
    if (wrStrobe === 1'b1) wrQ.push_back({regAddr, wrData});
  end
  task automatic summarize();
    if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // One transaction: address byte then n data bytes, then STOP
  task automatic xfer(input logic [7:0] a, input logic rd, input int n,
      input logic [7:0] d[4]);
    int i, k;
    rspQ.delete();
    ackQ.delete();
    wrQ.delete();
    @(negedge sys_clk);
    cmdValid = 1'b1;
    cmdAddr = a;
    cmdRead = 1'b0;
    cmdLast = 1'b0;
    for (i = 0; i <= n; i++) begin
      k = 0;
      do begin
        @(posedge sys_clk);
        k++;
      end while (cmdReady !== 1'b1 && k < 40000);
      if (k >= 40000) n_mismatch++;
      @(negedge sys_clk);
      if (i == n) cmdValid = 1'b0;
      else begin
        cmdRead = rd;
        cmdData = d[i];
        cmdLast = (i == n - 1);
      end
    end
    k = 0;
    while ((ackQ.size() < n + 1 || busy !== 1'b0) && k < 40000) begin
      @(negedge sys_clk);
      k++;
    end
    if (k >= 40000) n_mismatch++;
    repeat (150) @(negedge sys_clk);
  endtask
  logic [7:0] z[4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] held[2] = '{8'h0e, 8'h1b};
  localparam logic [7:0] W = {SLAVE_ADDR, 1'b0};
  localparam logic [7:0] R = {SLAVE_ADDR, 1'b1};
  initial begin
    cmdValid = 1'b0;
    cmdRead = 1'b0;
    cmdAddr = 8'h00;
    cmdData = 8'h00;
    cmdLast = 1'b0;
    repeat (5) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (5) @(negedge sys_clk);
    xfer(8'h6e, 1'b0, 0, z);
    check(ackQ[0], 1'b0);
    xfer(W, 1'b0, 3, '{8'h07, 8'ha1, 8'hb2, 8'h00});
    for (int i = 0; i < 4; i++) check(ackQ[i], 1'b1);
    check(wrQ[0], 16'h07a1);
    check(wrQ[1], 16'h08b2);
    xfer(W, 1'b0, 4, '{8'h09, 8'hc3, 8'hd4, 8'he5});
    check(ackQ[1], 1'b0);
    check({ackQ[2], ackQ[3], ackQ[4]}, 3'b001);
    check(wrQ.size(), 1);
    check(wrQ[0], 16'h0be5);
    xfer(R, 1'b1, 2, z);
    check(ackQ[0], 1'b1);
    check(rspQ[1], 8'h0c ^ 8'h5a);
    check(rspQ[2], 8'h0c ^ 8'h5a);
    foreach (held[j]) begin
      xfer(W, 1'b0, 1, '{held[j], 8'h00, 8'h00, 8'h00});
      xfer(R, 1'b1, 2, z);
      check({rspQ[1], rspQ[2]}, {2{held[j] ^ 8'h5a}});
    end
    xfer(W, 1'b0, 1, '{8'hfe, 8'h00, 8'h00, 8'h00});
    xfer(R, 1'b1, 3, z);
    check(rspQ[1], 8'h00);
    check(rspQ[3], 8'h5a);
    xfer(W, 1'b0, 3, '{8'hff, 8'h11, 8'h22, 8'h00});
    check(wrQ[1], 16'h0022);
    summarize();
  end
  initial begin
    #380000;
    n_mismatch++;
    summarize();
  end
endmodule
